// file: shared/sssl_consts.svh
// Summary of operation
// R1 - Character is spacing start, five selecting impulses, marking stop, in that order.
// R2 - Transmitter gives the start and selecting impulses the same fixed unit length.
// R3 - Five selecting impulses form a 5-bit code; all 32 values valid.
// R4 - Neutral line: current present is marking, no current is spacing.
// R5 - Polar line: marking is current one way, spacing current the other.
// R6 - Receiver starts one cycle on detecting the spacing start impulse.
// R7 - Receiver halts in the stop impulse until the next start impulse.
// R8 - Receiver cycle runs slightly faster, resting late in the stop impulse; the receiver here ends at its fifth sample and rests at the next mark.
// R9 - Receiver accepts neutral and polar; sender makes neutral by default.
// R10 - Parallel path presents all five impulses at one instant.
// R11 - Parallel actuator fed by keyboard locally, by receiver from the line.
// R12 - Keyboard sends serial to line or parallel code to the tape unit.
// R13 - Printing receiver takes only serial start-stop characters.
// R14 - Character spans 7.42 units; stop impulse takes the remaining 1.42.
// R15 - Sent characters also feed the local receiver for local copy.
// R16 - Half-duplex line: only one station sends at a time.
// R17 - Letter Y marks impulses one, three, five; spaces two and four.
// R18 - Receiver samples mid-unit, timed from start edge, by oversampling.
`ifndef SSSL_CONSTS_SVH
`define SSSL_CONSTS_SVH
`define SSSL_CLK_NS 50
`define SSSL_UNIT_NS 22000000
`define SSSL_OVS 16
`define SSSL_TX_LAST 5'h0f
`define SSSL_RX_LAST 5'h0e
`define SSSL_RX_HALF 5'h07
`define SSSL_STOP_CENTI 142
`define SSSL_CENTI 100
`define SSSL_BIT_LAST 3'h4
`define SSSL_CODE_Y 5'h15
`define SSSL_FIFO_DEPTH 8
`endif

// file: shared/sssl_pkg.sv
`default_nettype none
package sssl_pkg;
  typedef struct packed {
    logic par;
    logic [4:0] code;
  } sssl_char_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sssl_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sssl_rx_t;
  typedef struct packed {
    logic [15:0] div;
    logic tick;
    logic [1:0] sync;
    logic rprev;
    sssl_tx_t ts;
    logic [4:0] tsh;
    logic [2:0] tbit;
    logic [4:0] tcnt;
    logic tx_mark;
    sssl_rx_t rs;
    logic [4:0] rsh;
    logic [2:0] rbit;
    logic [4:0] rcnt;
    logic [4:0] par_code;
    logic par_stb;
    logic [4:0] prt_code;
    logic prt_stb;
  } sssl_state_t;
endpackage
`default_nettype wire

// file: rtl/sssl_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "sssl_consts.svh"

// ----------------------------------------
// Character FIFO
// ----------------------------------------
module sssl_fifo #(
  parameter int W = 6,
  parameter int D = `SSSL_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sssl_fptr_t;
  sssl_fptr_t st;
  sssl_fptr_t next_st;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
  assign out_valid = (st.wp != st.rp);
  assign out_data = mem[st.rp[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
  end

  // Register pointers; storage needs no reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wp[AW-1:0]] <= in_data;
    end
  end
endmodule // sssl_fifo

// ----------------------------------------
// Start-stop five-unit link
// ----------------------------------------
module sssl_link #(
  parameter int SUB_CYC = `SSSL_UNIT_NS / (`SSSL_OVS * `SSSL_CLK_NS),
  parameter bit TX_POLAR = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic kb_valid,
  output logic kb_ready,
  input wire sssl_pkg::sssl_char_t kb_char,
  input wire logic send_y,
  input wire logic line_in_pos,
  output logic line_out_pos,
  output logic line_out_neg,
  output logic tx_busy,
  output logic rx_busy,
  output logic [4:0] par_code,
  output logic par_stb,
  output logic [4:0] prt_code,
  output logic prt_stb
);
  localparam int STOP_TICKS =
    (`SSSL_STOP_CENTI * `SSSL_OVS + `SSSL_CENTI - 1) / `SSSL_CENTI;
  localparam logic [4:0] STOP_LAST = 5'(STOP_TICKS - 1);
  localparam logic [15:0] DIV_LAST = 16'(SUB_CYC - 1);

  sssl_pkg::sssl_state_t st;
  sssl_pkg::sssl_state_t next_st;
  logic q_valid;
  logic q_ready;
  sssl_pkg::sssl_char_t q_char;
  logic rx_in;
  logic rx_done;
  logic tx_go;

  // Keyboard characters queue here; the keyboard stalls when it fills
  sssl_fifo #(.W(6), .D(`SSSL_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(kb_valid), // see R3
    .in_ready(kb_ready),
    .in_data(kb_char),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_char)
  );

  // Local copy: while sending, the receiver hears our own impulses
  assign rx_in = (st.ts != sssl_pkg::TX_IDLE) ? st.tx_mark : st.sync[1]; // see R15
  // Line shared half-duplex: no send while a character is arriving
  assign tx_go = (st.ts == sssl_pkg::TX_IDLE) && (st.rs == sssl_pkg::RX_IDLE) && rx_in; // see R16
  assign rx_done = st.tick && (st.rs == sssl_pkg::RX_DATA) && (st.rcnt == `SSSL_RX_LAST)
    && (st.rbit == `SSSL_BIT_LAST);
  // Parallel entries yield to a receiver completion in the same cycle
  assign q_ready = q_char.par ? !rx_done : (tx_go && !send_y); // see R12

  // Line drive: neutral keys current for marking; polar reverses for spacing
  assign line_out_pos = st.tx_mark; // see R4
  assign line_out_neg = TX_POLAR && !st.tx_mark; // see R5 see R9
  assign tx_busy = (st.ts != sssl_pkg::TX_IDLE);
  assign rx_busy = (st.rs != sssl_pkg::RX_IDLE);
  assign par_code = st.par_code;
  assign par_stb = st.par_stb;
  assign prt_code = st.prt_code;
  assign prt_stb = st.prt_stb;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[0], line_in_pos};
    next_st.rprev = rx_in;
    next_st.par_stb = 1'b0;
    next_st.prt_stb = 1'b0;
    // Oversampling divider
    next_st.tick = (st.div == DIV_LAST);
    next_st.div = next_st.tick ? '0 : st.div + 1'b1;

    // Transmitter: start and selecting impulses each span one unit of OVS ticks
    case (st.ts)
      sssl_pkg::TX_IDLE: begin
        next_st.tx_mark = 1'b1;
        if (tx_go && (send_y || (q_valid && !q_char.par))) begin
          next_st.tsh = send_y ? `SSSL_CODE_Y : q_char.code; // see R17
          next_st.ts = sssl_pkg::TX_START;
          next_st.tx_mark = 1'b0; // see R1
          next_st.tcnt = '0;
          next_st.tbit = '0;
        end
      end
      sssl_pkg::TX_START: begin
        if (st.tick) begin
          next_st.tcnt = st.tcnt + 1'b1;
          if (st.tcnt == `SSSL_TX_LAST) begin // see R2
            next_st.tcnt = '0;
            next_st.ts = sssl_pkg::TX_DATA;
            next_st.tx_mark = st.tsh[0];
          end
        end
      end
      sssl_pkg::TX_DATA: begin
        if (st.tick) begin
          next_st.tcnt = st.tcnt + 1'b1;
          if (st.tcnt == `SSSL_TX_LAST) begin // see R2
            next_st.tcnt = '0;
            if (st.tbit == `SSSL_BIT_LAST) begin
              next_st.ts = sssl_pkg::TX_STOP;
              next_st.tx_mark = 1'b1; // see R1
            end else begin
              next_st.tbit = st.tbit + 1'b1;
              next_st.tsh = {1'b0, st.tsh[4:1]};
              next_st.tx_mark = st.tsh[1];
            end
          end
        end
      end
      sssl_pkg::TX_STOP: begin
        // Stop fills out the 7.42-unit character
        if (st.tick) begin
          next_st.tcnt = st.tcnt + 1'b1;
          if (st.tcnt == STOP_LAST) begin // see R14
            next_st.ts = sssl_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_st.ts = sssl_pkg::TX_IDLE;
      end
    endcase

    // Receiver: units of 15 ticks so it finishes ahead of the sender
    case (st.rs)
      sssl_pkg::RX_IDLE: begin
        if (st.rprev && !rx_in) begin // see R6
          next_st.rs = sssl_pkg::RX_START;
          next_st.rcnt = '0;
          next_st.rbit = '0;
        end
      end
      sssl_pkg::RX_START: begin
        if (st.tick) begin
          next_st.rcnt = st.rcnt + 1'b1;
          if (st.rcnt == `SSSL_RX_HALF) begin // see R18
            // A marking line at mid-start was noise; go back to rest
            next_st.rs = rx_in ? sssl_pkg::RX_IDLE : sssl_pkg::RX_DATA;
            next_st.rcnt = '0;
          end
        end
      end
      sssl_pkg::RX_DATA: begin
        if (st.tick) begin
          next_st.rcnt = st.rcnt + 1'b1;
          if (st.rcnt == `SSSL_RX_LAST) begin // see R8 see R18
            next_st.rcnt = '0;
            next_st.rsh = {rx_in, st.rsh[4:1]};
            next_st.rbit = st.rbit + 1'b1;
            if (st.rbit == `SSSL_BIT_LAST) begin
              next_st.rs = sssl_pkg::RX_STOP;
              next_st.prt_code = {rx_in, st.rsh[4:1]}; // see R13
              next_st.prt_stb = 1'b1;
              next_st.par_code = {rx_in, st.rsh[4:1]}; // see R11
              next_st.par_stb = 1'b1;
            end
          end
        end
      end
      sssl_pkg::RX_STOP: begin
        // Rest at the next mark (a marking fifth impulse or the stop), then wait for a start
        if (rx_in) begin // see R7
          next_st.rs = sssl_pkg::RX_IDLE;
        end
      end
      default: begin
        next_st.rs = sssl_pkg::RX_IDLE;
      end
    endcase

    // Keyboard parallel character straight to the actuator
    if (q_valid && q_ready && q_char.par) begin
      next_st.par_code = q_char.code; // see R10 see R11
      next_st.par_stb = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '{sync: 2'h3, rprev: 1'b1, tx_mark: 1'b1, ts: sssl_pkg::TX_IDLE,
              rs: sssl_pkg::RX_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_start_space: assert property ( // see R1
    (st.ts == sssl_pkg::TX_START) |-> !line_out_pos)
    else $error("start impulse not spacing");
  a_stop_mark: assert property ( // see R1
    (st.ts == sssl_pkg::TX_STOP) |-> line_out_pos && (st.tbit == `SSSL_BIT_LAST))
    else $error("stop impulse not marking after five");
  a_unit_fixed: assert property ( // see R2
    (st.ts == sssl_pkg::TX_DATA) && st.tick && (st.tcnt != `SSSL_TX_LAST)
      |=> $stable(line_out_pos))
    else $error("impulse changed inside a unit");
  a_stop_len: assert property ( // see R14
    (st.ts == sssl_pkg::TX_STOP) && st.tick && (st.tcnt == STOP_LAST)
      |=> (st.ts == sssl_pkg::TX_IDLE))
    else $error("stop impulse length wrong");
  a_stop_bound: assert property ( // see R14
    (st.ts == sssl_pkg::TX_STOP) |-> (st.tcnt <= STOP_LAST))
    else $error("stop impulse overran its count");
  a_neutral_tx: assert property ( // see R9
    !TX_POLAR |-> !line_out_neg)
    else $error("neutral sender drove reverse current");
  a_rx_begin: assert property ( // see R6
    (st.rs == sssl_pkg::RX_IDLE) && st.rprev && !rx_in |=> (st.rs == sssl_pkg::RX_START))
    else $error("start impulse missed");
  a_rx_rest: assert property ( // see R7
    (st.rs == sssl_pkg::RX_STOP) && rx_in |=> (st.rs == sssl_pkg::RX_IDLE))
    else $error("receiver did not rest on stop");
  a_local_copy: assert property ( // see R15 see R16
    tx_busy |-> (rx_in == line_out_pos) && !($rose(tx_busy) && $past(rx_busy)))
    else $error("local copy or half-duplex broken");
  a_prt_par: assert property ( // see R10 see R11
    prt_stb |-> par_stb && (par_code == prt_code))
    else $error("parallel actuator missed received code");
endmodule // sssl_link
`default_nettype wire

// file: testbench/sssl_far_station.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Remote start-stop station
// ----------------------------------------
module sssl_far_station #(
  parameter int UNIT = 64,
  parameter int STOP = 92
) (
  input wire logic clk,
  input wire logic send_go,
  input wire logic [4:0] send_code,
  input wire logic line_rx,
  output logic line_tx,
  output logic send_busy,
  output logic got_stb,
  output logic [4:0] got_code,
  output logic got_ok
);
  logic [6:0] frame;
  logic ok;

  // Sender: rests at mark, so an idle line never reads as a start
  initial begin
    line_tx = 1'b1;
    send_busy = 1'b0;
    forever begin
      @(posedge clk);
      if (send_go) begin
        send_busy <= 1'b1;
        frame = {1'b1, send_code, 1'b0};
        for (int i = 0; i < 7; i++) begin
          line_tx <= frame[i];
          repeat (i == 6 ? STOP : UNIT) @(posedge clk);
        end
        send_busy <= 1'b0;
      end
    end
  end

  // Receiver: samples mid-unit, far from the edges where the line moves
  initial begin
    got_stb = 1'b0;
    got_code = 5'h00;
    got_ok = 1'b0;
    forever begin
      @(posedge clk);
      got_stb <= 1'b0;
      if (line_rx === 1'b0) begin
        repeat (UNIT / 2) @(posedge clk);
        ok = (line_rx === 1'b0);
        for (int i = 0; i < 5; i++) begin
          repeat (UNIT) @(posedge clk);
          got_code[i] <= line_rx;
        end
        repeat (UNIT) @(posedge clk);
        got_ok <= ok && (line_rx === 1'b1);
        got_stb <= 1'b1;
        while (line_rx !== 1'b1) @(posedge clk);
      end
    end
  end
endmodule // sssl_far_station
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Link testbench
// ----------------------------------------
module testbench;
  logic clk, sys_rst, kb_valid, send_y, far_go;
  sssl_pkg::sssl_char_t kb_char;
  logic [4:0] far_in, far_code, par_code, prt_code;
  logic kb_ready, line_in_pos, line_out_pos, line_out_neg, tx_busy, rx_busy;
  logic par_stb, prt_stb, far_stb, far_ok, pol_pos, pol_neg;
  int fails, num_checks, n, k;
  // Rows {kind, code}: kind 0 serial key, 1 parallel key, 2 from the line
  logic [6:0] rows [7] = '{7'h15, 7'h00, 7'h1f, 7'h2a, 7'h35, 7'h51, 7'h4e};

  sssl_link #(.SUB_CYC(4)) dut_u (.clk(clk), .sys_rst(sys_rst), .kb_valid(kb_valid),
    .kb_ready(kb_ready), .kb_char(kb_char), .send_y(send_y), .line_in_pos(line_in_pos),
    .line_out_pos(line_out_pos), .line_out_neg(line_out_neg), .tx_busy(tx_busy),
    .rx_busy(rx_busy), .par_code(par_code), .par_stb(par_stb), .prt_code(prt_code),
    .prt_stb(prt_stb));

  // Polar build of the same link, fed alike, to watch reverse current
  sssl_link #(.SUB_CYC(4), .TX_POLAR(1'b1)) dut_pol_u (.clk(clk), .sys_rst(sys_rst),
    .kb_valid(kb_valid), .kb_ready(), .kb_char(kb_char), .send_y(send_y),
    .line_in_pos(line_in_pos), .line_out_pos(pol_pos), .line_out_neg(pol_neg),
    .tx_busy(), .rx_busy(), .par_code(), .par_stb(), .prt_code(), .prt_stb());

  sssl_far_station #(.UNIT(64), .STOP(92)) far_u (.clk(clk), .send_go(far_go),
    .send_code(far_in), .line_rx(line_out_pos), .line_tx(line_in_pos), .send_busy(),
    .got_stb(far_stb), .got_code(far_code), .got_ok(far_ok));

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Offer one key character and hold it until an edge with room
  task automatic push(input logic p, input logic [4:0] c);
    logic ok;
    kb_valid <= 1'b1;
    kb_char <= {p, c};
    ok = 1'b0;
    while (!ok) begin
      @(negedge clk);
      ok = (kb_ready === 1'b1);
      @(posedge clk);
    end
    kb_valid <= 1'b0;
  endtask

  // Bounded wait: 0 printer strobe, 1 remote got, 2 parallel strobe, 3 tx busy
  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if ((sel == 0 && prt_stb === 1'b1) || (sel == 1 && far_stb === 1'b1) ||
          (sel == 2 && par_stb === 1'b1) || (sel == 3 && tx_busy === 1'b1)) break;
    end
    if (i == 3000) check(16'h0000, 16'h0001);
  endtask

  // Remote starts a character on a one-cycle go pulse, whether or not this end is quiet
  task automatic remote(input logic [4:0] c);
    far_in <= c;
    far_go <= 1'b1;
    @(posedge clk);
    far_go <= 1'b0;
  endtask

  // Watchdog, well beyond the expected run of some 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    kb_valid = 1'b0;
    kb_char = '0;
    send_y = 1'b0;
    far_go = 1'b0;
    far_in = 5'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check({line_out_pos, line_out_neg, tx_busy, rx_busy, par_stb, prt_stb, kb_ready},
      7'h41);
    check({pol_pos, pol_neg}, 2'h2);
    $display("test reset done");
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      case (rows[i][6:5])
        2'd0: begin
          push(1'b0, rows[i][4:0]);
          wait_hi(0);
          check(prt_code, rows[i][4:0]);
          wait_hi(1);
          check({far_ok, far_code}, {1'b1, rows[i][4:0]});
        end
        2'd1: begin
          push(1'b1, rows[i][4:0]);
          wait_hi(2);
          check(par_code, rows[i][4:0]);
        end
        default: begin
          remote(rows[i][4:0]);
          wait_hi(0);
          check(prt_code, rows[i][4:0]);
          check(par_code, rows[i][4:0]);
        end
      endcase
      repeat (200) @(posedge clk);
      $display("test row %0d done", i);
    end
    // Character length and shape on the wire
    push(1'b0, 5'h1f);
    wait_hi(3);
    check(line_out_pos, 1'b0);
    for (n = 0; n < 1000 && tx_busy === 1'b1; n++) begin
      if (n == 200) check(line_out_neg, 1'b0);
      if (n == 200) check({pol_pos, pol_neg}, {line_out_pos, ~line_out_pos});
      @(negedge clk);
    end
    check(n >= 470 && n <= 480, 1'b1);
    repeat (100) @(posedge clk);
    $display("test length done");
    // Key character queued while the remote holds the line
    remote(5'h03);
    repeat (8) @(posedge clk);
    push(1'b0, 5'h0c);
    wait_hi(0);
    check({line_out_pos, prt_code}, {1'b1, 5'h03});
    wait_hi(1);
    check(far_code, 5'h0c);
    repeat (200) @(posedge clk);
    $display("test half duplex done");
    // Test-pattern letter on request
    send_y <= 1'b1;
    wait_hi(3);
    @(posedge clk);
    send_y <= 1'b0;
    wait_hi(1);
    check(far_code, 5'h15);
    repeat (200) @(posedge clk);
    $display("test letter y done");
    // Fill the buffer until refused, then drain in order
    kb_valid <= 1'b1;
    kb_char <= '0;
    n = 0;
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      if (kb_ready !== 1'b1) break;
      @(posedge clk);
      n++;
      kb_char <= {1'b0, 5'(n)};
    end
    @(posedge clk);
    kb_valid <= 1'b0;
    check({k < 20, n >= 8}, 2'h3);
    for (int j = 0; j < n; j++) begin
      wait_hi(1);
      check(far_code, 5'(j));
    end
    check(kb_ready, 1'b1);
    $display("test buffer done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
